// >>> logic/tc0_cfg.svh
// timer0 control block: offsets, field positions, reset values, divider masks
`ifndef TC0_CFG_SVH
`define TC0_CFG_SVH

// ----------------------------------------------------------------
// register offsets, data space
// ----------------------------------------------------------------
`define TC0_OFS_SYNC_CTRL 8'h43
`define TC0_OFS_CTRL_B 8'h45
`define TC0_OFS_COUNT 8'h46
`define TC0_OFS_CMP_A 8'h47
`define TC0_OFS_IRQ_FLAG 8'h35
`define TC0_OFS_IRQ_MASK 8'h6E

// ----------------------------------------------------------------
// i/o space alias window
// ----------------------------------------------------------------
`define TC0_IO_BASE 8'h20
`define TC0_IO_END 8'h60

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TC0_FORCE_A_BIT 7
`define TC0_FORCE_B_BIT 6
`define TC0_WGM2_BIT 3
`define TC0_TSM_BIT 7
`define TC0_PSR_ASY_BIT 1
`define TC0_PSR_SYNC_BIT 0

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define TC0_RST_VAL 8'h00
`define TC0_MAX 8'hFF
`define TC0_BOTTOM 8'h00
`define TC0_DIV8_MASK 10'h007
`define TC0_DIV64_MASK 10'h03F
`define TC0_DIV256_MASK 10'h0FF
`define TC0_DIV1024_MASK 10'h3FF

`endif

// >>> logic/tc0_ctrl.sv
// timer0 control block: registers, counter, compare, waveform and irq requests
// Summary of operation
// - force A only in non-PWM modes
// - force A acts on wave A now
// - forced A match: no flag, no clear
// - force bits are strobes, read zero
// - force B acts on wave B, non-PWM
// - forced B match: no flag, no clear
// - clock select: stop or prescaled ticks
// - codes 110/111 count pin falls/rises
// - pin edges count even as output
// - B irq needs enable, global, flag
// - A irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - sync hold keeps prescaler resets asserted
// - releasing hold clears both resets
// - async clear self-clears unless held/busy
// - sync clear resets prescaler, self-clears unless held
// - counter readable and writable anytime
// - counter write blocks next match
// - compare A checked continuously
// - low registers alias at offset minus 0x20
// - output mode: none, toggle, clear, set
// - flags clear by vector or write-one
`timescale 1ns/10ps
`include "tc0_cfg.svh"
module tc0_ctrl
(
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic [7:0] ADDR_I,
   input wire logic IO_SPACE_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] WDATA_I,
   input wire logic [1:0] WAVE_MODE_LOW_I,
   input wire logic [1:0] OUT_MODE_A_I,
   input wire logic [1:0] OUT_MODE_B_I,
   input wire logic [7:0] COMPARE_VALUE_B_I,
   input wire logic GIE_I,
   input wire logic [2:0] VEC_ACK_I,
   input wire logic EXT_COUNT_PIN_I,
   input wire logic ASYNC_MODE_I,
   input wire logic ASYNC_DONE_I,
   output logic [7:0] RDATA_O,
   output logic [2:0] IRQ_O,
   output logic WAVE_OUT_A_O,
   output logic WAVE_OE_N_A_O,
   output logic WAVE_OUT_B_O,
   output logic WAVE_OE_N_B_O,
   output logic SYNC_PRESCALE_CLEAR_O,
   output logic ASYNC_PRESCALE_CLEAR_O
);
   logic [7:0] cnt_q;
   logic [7:0] cmp_a_q;
   logic [7:0] rdata_q;
   logic wgm2_q;
   tc0_pkg::tc0_clk_sel_t clk_sel_q;
   logic [2:0] irq_en_q;
   logic [2:0] flag_q;
   logic [2:0] irq_q;
   logic tsm_q;
   logic async_prescale_clear_q;
   logic sync_prescale_clear_q;
   logic block_q;
   logic down_q;
   logic [1:0] wave_q;
   logic [1:0] oe_n_q;
   logic hit_sync;
   logic hit_ctrlb;
   logic hit_cnt;
   logic hit_cmpa;
   logic hit_mask;
   logic hit_flag;
   logic wr_sync;
   logic wr_ctrlb;
   logic wr_cnt;
   logic [2:0] wgm;
   logic pwm;
   logic phase;
   logic fast;
   logic [7:0] top;
   logic at_top;
   logic presc_tick;
   logic pin_rise;
   logic pin_fall;
   logic tick;
   logic ovf_evt;
   logic [1:0] match_v;
   logic [1:0] force_v;
   logic [3:0] com_all;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] addr, input logic io,
      input logic [7:0] offs);
      logic hit;
      hit = (addr == offs);
      if (io)
         hit = (offs >= `TC0_IO_BASE) && (offs < `TC0_IO_END)
            && (addr == offs - `TC0_IO_BASE);
      return hit;
   endfunction

   function automatic logic wave_act(input logic cur, input logic [1:0] mode,
      input logic inv);
      logic nxt;
      nxt = cur;
      case (mode)
         2'b01: nxt = !cur;
         2'b10: nxt = inv;
         2'b11: nxt = !inv;
         default: nxt = cur;
      endcase
      return nxt;
   endfunction

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // alias decode
   assign hit_sync = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_SYNC_CTRL);
   assign hit_ctrlb = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_CTRL_B);
   assign hit_cnt = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_COUNT);
   assign hit_cmpa = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_CMP_A);
   assign hit_mask = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_IRQ_MASK);
   assign hit_flag = reg_hit(ADDR_I, IO_SPACE_I, `TC0_OFS_IRQ_FLAG);
   assign wr_sync = WR_I && hit_sync;
   assign wr_ctrlb = WR_I && hit_ctrlb;
   assign wr_cnt = WR_I && hit_cnt;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   assign wgm = {wgm2_q, WAVE_MODE_LOW_I};
   assign pwm = wgm[0];
   assign phase = (wgm[1:0] == 2'b01);
   assign fast = (wgm[1:0] == 2'b11);
   assign top = ((wgm == 3'b010) || (wgm[2] && wgm[0])) ? cmp_a_q : `TC0_MAX;
   assign at_top = (cnt_q == top);
   assign com_all = {OUT_MODE_B_I, OUT_MODE_A_I};

   // ----------------------------------------------------------------
   // clock select
   // ----------------------------------------------------------------
   // shared prescaler
   tc0_prescaler u_presc
   (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .clear_i(sync_prescale_clear_q),
      .sel_i(clk_sel_q),
      .tick_o(presc_tick)
   );

   tc0_ext_edge u_edge
   (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(EXT_COUNT_PIN_I),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   always_comb
   begin
      unique case (clk_sel_q)
         tc0_pkg::TC0_CS_EXT_FALL: tick = pin_fall;
         tc0_pkg::TC0_CS_EXT_RISE: tick = pin_rise;
         default: tick = presc_tick;
      endcase
   end

   // ----------------------------------------------------------------
   // control register b and compare register a
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         wgm2_q <= 1'b0;
         clk_sel_q <= tc0_pkg::TC0_CS_STOP;
      end
      else if (wr_ctrlb)
      begin
         wgm2_q <= WDATA_I[`TC0_WGM2_BIT];
         clk_sel_q <= tc0_pkg::tc0_clk_sel_t'(WDATA_I[2:0]);
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         cmp_a_q <= `TC0_RST_VAL;
      else if (WR_I && hit_cmpa)
         cmp_a_q <= WDATA_I;
   end

   assign force_v[0] = wr_ctrlb && WDATA_I[`TC0_FORCE_A_BIT] && !pwm;
   assign force_v[1] = wr_ctrlb && WDATA_I[`TC0_FORCE_B_BIT] && !pwm;

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   // direct write wins
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         cnt_q <= `TC0_RST_VAL;
         down_q <= 1'b0;
      end
      else if (wr_cnt)
         cnt_q <= WDATA_I;
      else if (tick && phase)
      begin
         if (!down_q && at_top)
         begin
            down_q <= 1'b1;
            cnt_q <= cnt_q - 8'h01;
         end
         else if (down_q && cnt_q == `TC0_BOTTOM)
         begin
            down_q <= 1'b0;
            cnt_q <= cnt_q + 8'h01;
         end
         else
            cnt_q <= down_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
      end
      else if (tick)
      begin
         down_q <= 1'b0;
         cnt_q <= at_top ? `TC0_BOTTOM : cnt_q + 8'h01;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         block_q <= 1'b0;
      else if (wr_cnt)
         block_q <= 1'b1;
      else if (tick)
         block_q <= 1'b0;
   end

   assign match_v[0] = tick && !block_q && (cnt_q == cmp_a_q);
   assign match_v[1] = tick && !block_q && (cnt_q == COMPARE_VALUE_B_I);
   assign ovf_evt = tick && (phase ? (down_q && cnt_q == `TC0_BOTTOM)
      : (cnt_q == `TC0_MAX || (wgm == 3'b111 && at_top)));

   // ----------------------------------------------------------------
   // waveform outputs
   // ----------------------------------------------------------------
   genvar g;
   for (g = 0; g < 2; g++)
   begin : g_wave
      logic [1:0] com;
      logic [1:0] com_eff;
      assign com = com_all[2*g +: 2];
      assign com_eff = (pwm && com == 2'b01 && !((g == 0) && wgm2_q)) ? 2'b00 : com;

      always_ff @(posedge MCLK_I)
      begin
         if (!RST_N_I)
         begin
            wave_q[g] <= 1'b0;
            oe_n_q[g] <= 1'b1;
         end
         else
         begin
            oe_n_q[g] <= (com == 2'b00);
            if (force_v[g])
               wave_q[g] <= wave_act(wave_q[g], com_eff, 1'b0);
            else if (match_v[g])
               wave_q[g] <= wave_act(wave_q[g], com_eff, phase && down_q);
            else if (tick && fast && at_top && com[1])
               wave_q[g] <= wave_act(wave_q[g], com, 1'b1);
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt mask, flags and requests
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         irq_en_q <= 3'h0;
      else if (WR_I && hit_mask)
         irq_en_q <= WDATA_I[2:0];
   end

   assign flag_set = {match_v[1], match_v[0], ovf_evt};
   assign flag_clr = VEC_ACK_I | ((WR_I && hit_flag) ? WDATA_I[2:0] : 3'h0);

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         flag_q <= 3'h0;
      else
         flag_q <= (flag_q & ~flag_clr) | flag_set;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
         irq_q <= 3'h0;
      else
         irq_q <= irq_en_q & flag_q & {3{GIE_I}};
   end

   // ----------------------------------------------------------------
   // synchronisation control
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         tsm_q <= 1'b0;
         async_prescale_clear_q <= 1'b0;
         sync_prescale_clear_q <= 1'b0;
      end
      else if (wr_sync)
      begin
         tsm_q <= WDATA_I[`TC0_TSM_BIT];
         if (tsm_q && !WDATA_I[`TC0_TSM_BIT])
         begin
            async_prescale_clear_q <= 1'b0;
            sync_prescale_clear_q <= 1'b0;
         end
         else
         begin
            async_prescale_clear_q <= WDATA_I[`TC0_PSR_ASY_BIT];
            sync_prescale_clear_q <= WDATA_I[`TC0_PSR_SYNC_BIT];
         end
      end
      else if (!tsm_q)
      begin
         sync_prescale_clear_q <= 1'b0;
         if (!ASYNC_MODE_I || ASYNC_DONE_I)
            async_prescale_clear_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // strobes and unused bits read zero
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I || !RD_I)
         rdata_q <= 8'h00;
      else if (hit_sync)
         rdata_q <= {tsm_q, 5'h00, async_prescale_clear_q, sync_prescale_clear_q};
      else if (hit_ctrlb)
         rdata_q <= {4'h0, wgm2_q, clk_sel_q};
      else if (hit_cnt)
         rdata_q <= cnt_q;
      else if (hit_cmpa)
         rdata_q <= cmp_a_q;
      else if (hit_mask)
         rdata_q <= {5'h00, irq_en_q};
      else if (hit_flag)
         rdata_q <= {5'h00, flag_q};
      else
         rdata_q <= 8'h00;
   end

   assign RDATA_O = rdata_q;
   assign IRQ_O = irq_q;
   assign WAVE_OUT_A_O = wave_q[0];
   assign WAVE_OUT_B_O = wave_q[1];
   assign WAVE_OE_N_A_O = oe_n_q[0];
   assign WAVE_OE_N_B_O = oe_n_q[1];
   assign SYNC_PRESCALE_CLEAR_O = sync_prescale_clear_q;
   assign ASYNC_PRESCALE_CLEAR_O = async_prescale_clear_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   a_force_a_pwm: assert property (wr_ctrlb && pwm |-> !force_v[0])
      else $error("force A taken in pwm mode");
   a_force_a_clear: assert property (force_v[0] && OUT_MODE_A_I == 2'b10
      |=> !WAVE_OUT_A_O)
      else $error("force A did not clear wave A");
   a_force_no_count: assert property (force_v[0] && !tick && !wr_cnt
      |=> $stable(cnt_q) && !flag_q[1])
      else $error("force A changed counter or flag");
   a_force_read_zero: assert property (RD_I && hit_ctrlb |=> RDATA_O[7:4] == 4'h0)
      else $error("force bits read nonzero");
   a_force_b_set: assert property (force_v[1] && OUT_MODE_B_I == 2'b11
      |=> WAVE_OUT_B_O)
      else $error("force B did not set wave B");
   a_stop_holds: assert property (clk_sel_q == tc0_pkg::TC0_CS_STOP && !wr_cnt
      |=> $stable(cnt_q))
      else $error("stopped counter moved");
   a_ext_rise_tick: assert property (clk_sel_q == tc0_pkg::TC0_CS_EXT_RISE
      |-> tick == pin_rise)
      else $error("rise select does not follow pin");
   a_irq_b_gate: assert property (IRQ_O[2] |-> $past(GIE_I && irq_en_q[2] && flag_q[2]))
      else $error("B irq without cause");
   a_irq_a_gate: assert property (flag_q[1] && irq_en_q[1] && GIE_I
      |=> IRQ_O[1])
      else $error("A irq missing");
   a_irq_ovf_gate: assert property (!irq_en_q[0] |=> !IRQ_O[0])
      else $error("overflow irq while masked");
   a_tsm_keeps: assert property (tsm_q && sync_prescale_clear_q && !wr_sync
      |=> sync_prescale_clear_q)
      else $error("sync reset dropped under hold");
   a_tsm_release: assert property (wr_sync && tsm_q && !WDATA_I[7]
      |=> !sync_prescale_clear_q && !async_prescale_clear_q)
      else $error("release left resets set");
   a_sync_selfclr: assert property (sync_prescale_clear_q && !tsm_q && !wr_sync |=> !sync_prescale_clear_q)
      else $error("sync reset did not self clear");
   a_cnt_write: assert property (wr_cnt |=> cnt_q == $past(WDATA_I))
      else $error("counter write lost");
   a_write_blocks: assert property (wr_cnt ##1 tick |-> match_v == 2'b00)
      else $error("match after counter write");
   a_ctc_wrap: assert property (wgm == 3'b010 && match_v[0] && !wr_cnt
      |=> cnt_q == `TC0_BOTTOM)
      else $error("ctc did not wrap at compare A");
   a_io_alias: assert property (IO_SPACE_I && ADDR_I == 8'h26 && WR_I |-> wr_cnt)
      else $error("io alias not decoded");
   a_flag_set_wins: assert property (flag_set[1] && flag_clr[1] |=> flag_q[1])
      else $error("flag set lost to clear");

   c_force_a: cover property (force_v[0] ##1 WAVE_OUT_A_O);
   c_ctc_match: cover property (wgm == 3'b010 && match_v[0]);
   c_ext_count: cover property (clk_sel_q == tc0_pkg::TC0_CS_EXT_FALL && tick);
   c_tsm_release: cover property (tsm_q ##1 !tsm_q && !sync_prescale_clear_q);
endmodule // tc0_ctrl

// >>> logic/tc0_ext_edge.sv
// timer0 control block: edge detector for the external count pin
`timescale 1ns/10ps
module tc0_ext_edge
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic prev_q;

   // ----------------------------------------------------------------
   // previous pin level
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         prev_q <= 1'b0;
      else
         prev_q <= pin_i;
   end

   assign rise_o = pin_i && !prev_q;
   assign fall_o = !pin_i && prev_q;
endmodule // tc0_ext_edge

// >>> logic/tc0_pkg.sv
// timer0 control block: shared types
package tc0_pkg;
   typedef enum logic [2:0]
   {
      TC0_CS_STOP = 3'b000,
      TC0_CS_DIV1 = 3'b001,
      TC0_CS_DIV8 = 3'b010,
      TC0_CS_DIV64 = 3'b011,
      TC0_CS_DIV256 = 3'b100,
      TC0_CS_DIV1024 = 3'b101,
      TC0_CS_EXT_FALL = 3'b110,
      TC0_CS_EXT_RISE = 3'b111
   } tc0_clk_sel_t;
endpackage

// >>> logic/tc0_prescaler.sv
// timer0 control block: shared prescaler with tick selection
`timescale 1ns/10ps
`include "tc0_cfg.svh"
module tc0_prescaler
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input tc0_pkg::tc0_clk_sel_t sel_i,
   output logic tick_o
);
   logic [9:0] div_q;
   logic [9:0] mask;

   // ----------------------------------------------------------------
   // divider chain, held at zero while cleared
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || clear_i)
         div_q <= 10'h000;
      else
         div_q <= div_q + 10'h001;
   end

   always_comb
   begin
      mask = 10'h000;
      unique case (sel_i)
         tc0_pkg::TC0_CS_DIV8: mask = `TC0_DIV8_MASK;
         tc0_pkg::TC0_CS_DIV64: mask = `TC0_DIV64_MASK;
         tc0_pkg::TC0_CS_DIV256: mask = `TC0_DIV256_MASK;
         tc0_pkg::TC0_CS_DIV1024: mask = `TC0_DIV1024_MASK;
         tc0_pkg::TC0_CS_STOP, tc0_pkg::TC0_CS_DIV1,
         tc0_pkg::TC0_CS_EXT_FALL, tc0_pkg::TC0_CS_EXT_RISE: mask = 10'h000;
      endcase
   end

   // ----------------------------------------------------------------
   // tick output
   // ----------------------------------------------------------------
   always_comb
   begin
      tick_o = 1'b0;
      if (!clear_i && sel_i != tc0_pkg::TC0_CS_STOP && !sel_i[2] | !sel_i[1])
         tick_o = ((div_q & mask) == mask);
   end
endmodule // tc0_prescaler

// >>> tb/tc0_ctrl_tb.sv
// testbench for the timer0 control block
`timescale 1ns/10ps
module tc0_ctrl_tb;
   logic mclk, rst_n, io_space, wr, rd, gie, pin, line_a, async_mode, async_done;
   logic wa, wa_oe_n, wb, wb_oe_n, sclr, aclr;
   logic [7:0] addr, wdata, rdata, cmp_b, rv;
   logic [1:0] wave_lo, om_a, om_b;
   logic [2:0] vec_ack, irq;
   int failures, num_checks;
   int divs[5] = '{1, 8, 64, 256, 1024};
   logic [7:0] regs[6] = '{8'h43, 8'h45, 8'h46, 8'h47, 8'h6E, 8'h35};
   logic [1:0] md[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   logic ex[4] = '{1'h1, 1'h0, 1'h1, 1'h0};

   tc0_ctrl i_dut
   (
      .MCLK_I(mclk), .RST_N_I(rst_n), .ADDR_I(addr), .IO_SPACE_I(io_space),
      .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .WAVE_MODE_LOW_I(wave_lo),
      .OUT_MODE_A_I(om_a), .OUT_MODE_B_I(om_b), .COMPARE_VALUE_B_I(cmp_b),
      .GIE_I(gie), .VEC_ACK_I(vec_ack), .EXT_COUNT_PIN_I(pin),
      .ASYNC_MODE_I(async_mode), .ASYNC_DONE_I(async_done), .RDATA_O(rdata),
      .IRQ_O(irq), .WAVE_OUT_A_O(wa), .WAVE_OE_N_A_O(wa_oe_n), .WAVE_OUT_B_O(wb),
      .WAVE_OE_N_B_O(wb_oe_n), .SYNC_PRESCALE_CLEAR_O(sclr),
      .ASYNC_PRESCALE_CLEAR_O(aclr)
   );

   tc0_pin_model i_pin
   (
      .clk_i(mclk), .wave_a_i(wa), .wave_oe_n_a_i(wa_oe_n), .pin_o(pin), .line_a_o(line_a)
   );

   initial
   begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   // ---------------------------------
   // bus tasks and checks
   // ---------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic io = 1'h0);
      @(posedge mclk);
      #1 addr = a;
      io_space = io;
      wdata = d;
      wr = 1'h1;
      @(posedge mclk);
      #1 wr = 1'h0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      #1 addr = a;
      io_space = 1'h0;
      rd = 1'h1;
      @(posedge mclk);
      #1 rd = 1'h0;
      v = rdata;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd_reg(a, v);
      chk(v, exp);
   endtask

   task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      num_checks++;
      if (!((got >= lo) === 1'h1 && (got <= hi) === 1'h1))
      begin
         $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
         failures++;
      end
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wait_irq(input logic [2:0] exp);
      int k;
      k = 0;
      while (irq !== exp && k < 20)
      begin
         cyc(1);
         k++;
      end
      if (k == 20)
      begin
         failures++;
         finish_test();
      end
      chk(irq, exp);
   endtask

   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial
   begin
      rst_n = 1'h0; io_space = 1'h0; wr = 1'h0; rd = 1'h0; gie = 1'h0;
      async_mode = 1'h0; async_done = 1'h0; addr = 8'h00; wdata = 8'h00;
      cmp_b = 8'h00; wave_lo = 2'h0; om_a = 2'h0; om_b = 2'h0; vec_ack = 3'h0;
      failures = 0; num_checks = 0;
      cyc(4);
      rst_n = 1'h1;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      wr_reg(8'h46, 8'h5A); rd_chk(8'h46, 8'h5A);
      wr_reg(8'h47, 8'hA5); rd_chk(8'h47, 8'hA5);
      wr_reg(8'h6E, 8'hFF); rd_chk(8'h6E, 8'h07);
      wr_reg(8'h45, 8'hC8); rd_chk(8'h45, 8'h08);
      wr_reg(8'h43, 8'h7C); rd_chk(8'h43, 8'h00);
      wr_reg(8'h26, 8'h10, 1'h1); rd_chk(8'h46, 8'h10);
      wr_reg(8'h4E, 8'h00, 1'h1); rd_chk(8'h6E, 8'h07);
      rd_chk(8'h44, 8'h00);
      wr_reg(8'h45, 8'h00); wr_reg(8'h6E, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h46, 8'h00); wr_reg(8'h43, 8'h01); wr_reg(8'h45, 8'(i + 1));
         cyc(divs[i] * 4);
         wr_reg(8'h45, 8'h00); rd_reg(8'h46, rv);
         chk_rng(rv, 8'h03, 8'h08);
      end
      wr_reg(8'h46, 8'h33); cyc(30); rd_chk(8'h46, 8'h33);
      $display("test clock select done");
      wr_reg(8'h43, 8'h83); cyc(3); rd_chk(8'h43, 8'h83);
      chk(sclr, 8'h01); chk(aclr, 8'h01);
      wr_reg(8'h46, 8'h00); wr_reg(8'h45, 8'h01); cyc(10); rd_chk(8'h46, 8'h00);
      wr_reg(8'h43, 8'h00); chk(sclr, 8'h00); rd_chk(8'h43, 8'h00);
      wr_reg(8'h45, 8'h00); rd_reg(8'h46, rv); chk_rng(rv, 8'h01, 8'h08);
      wr_reg(8'h43, 8'h01); cyc(2); rd_chk(8'h43, 8'h00);
      async_mode = 1'h1;
      wr_reg(8'h43, 8'h02); cyc(4); chk(aclr, 8'h01);
      async_done = 1'h1; cyc(3); chk(aclr, 8'h00);
      async_done = 1'h0; async_mode = 1'h0;
      wr_reg(8'h43, 8'h02); cyc(2); rd_chk(8'h43, 8'h00);
      $display("test sync control done");
      wr_reg(8'h35, 8'h07); om_a = 2'h2; om_b = 2'h2;
      wr_reg(8'h45, 8'hC0); chk(wa, 8'h00); chk(wb, 8'h00);
      om_a = 2'h3; om_b = 2'h3; cmp_b = 8'h05; gie = 1'h1;
      wr_reg(8'h47, 8'h05); wr_reg(8'h6E, 8'h06); wr_reg(8'h45, 8'h07);
      wr_reg(8'h46, 8'h05); i_pin.pulse(1); cyc(3);
      rd_chk(8'h35, 8'h00); chk(wa, 8'h00); rd_chk(8'h46, 8'h06);
      wr_reg(8'h46, 8'h04); i_pin.pulse(2); cyc(3);
      rd_chk(8'h35, 8'h06); chk(wa, 8'h01); chk(wb, 8'h01);
      wait_irq(3'h6);
      gie = 1'h0; wait_irq(3'h0);
      gie = 1'h1; wait_irq(3'h6); wr_reg(8'h35, 8'h02); wait_irq(3'h4);
      vec_ack = 3'h4; cyc(1); vec_ack = 3'h0; wait_irq(3'h0);
      wr_reg(8'h45, 8'h06); wr_reg(8'h46, 8'hFE); wr_reg(8'h6E, 8'h01);
      i_pin.pulse(2); wait_irq(3'h1); rd_chk(8'h46, 8'h00);
      vec_ack = 3'h1; cyc(1); vec_ack = 3'h0; wait_irq(3'h0);
      $display("test matches done");
      wr_reg(8'h45, 8'h00); wr_reg(8'h46, 8'h20); wr_reg(8'h47, 8'h20);
      wr_reg(8'h35, 8'h07); wr_reg(8'h6E, 8'h00); wave_lo = 2'h2;
      for (int i = 0; i < 4; i++)
      begin
         om_a = md[i];
         wr_reg(8'h45, 8'h80); chk(wa, 8'(ex[i]));
      end
      rd_chk(8'h35, 8'h00); rd_chk(8'h46, 8'h20);
      om_b = 2'h2; wr_reg(8'h45, 8'h40); chk(wb, 8'h00);
      rd_chk(8'h35, 8'h00); rd_chk(8'h46, 8'h20);
      wave_lo = 2'h1; wr_reg(8'h45, 8'h00); om_a = 2'h3; om_b = 2'h3;
      wr_reg(8'h45, 8'hC0); chk(wa, 8'h00); chk(wb, 8'h00);
      om_a = 2'h0; cyc(2); chk(line_a, 8'h01);
      chk(wa_oe_n, 8'h01); chk(wb_oe_n, 8'h00);
      $display("test force done");
      finish_test();
   end
endmodule // tc0_ctrl_tb

// >>> tb/tc0_pin_model.sv
// pin-side model: external count pin driver, wave pin level with pull-up
`timescale 1ns/10ps
module tc0_pin_model
(
   input wire logic clk_i,
   input wire logic wave_a_i,
   input wire logic wave_oe_n_a_i,
   output logic pin_o,
   output logic line_a_o
);
   // released wave pin floats to the pull-up
   assign line_a_o = wave_oe_n_a_i ? 1'h1 : wave_a_i;
   initial pin_o = 1'h0;
   // ---------------------------------
   // count pin pulses
   // ---------------------------------
   // rise then fall
   task automatic pulse(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         #1 pin_o = 1'h1;
         repeat (2) @(posedge clk_i);
         #1 pin_o = 1'h0;
         repeat (2) @(posedge clk_i);
      end
   endtask
endmodule // tc0_pin_model
